// file: rtl/flow_regs.svh
// Purpose: named constants for the program-flow core
// Assumes: included by bare name wherever a constant is needed
// Notes:   instruction layout and register offsets live only here
`ifndef FLOW_REGS_SVH
`define FLOW_REGS_SVH
// major opcodes, instruction bits 15:12
`define OP_LOAD_K   4'h0
`define OP_LOAD_R   4'h1
`define OP_ADD_K    4'h2
`define OP_ADD_R    4'h3
`define OP_SUB_K    4'h4
`define OP_SUB_R    4'h5
`define OP_IN_K     4'h6
`define OP_IN_R     4'h7
`define OP_OUT_K    4'h8
`define OP_OUT_R    4'h9
`define OP_JUMP     4'hA
`define OP_CALL     4'hB
`define OP_RETURN   4'hC
`define OP_RETI     4'hD
`define OP_INTCTL   4'hE
// instruction fields
`define FLD_OP      15:12
`define FLD_RX      11:8
`define FLD_RY      7:4
`define FLD_K       7:0
`define FLD_COND    10:8
`define FLD_EN      0
`define COND_TEST   2
`define COND_CARRY  1
`define COND_INV    0
// program counter
`define PC_RESET    8'h00
`define PC_STEP     8'h01
`define IRQ_VECTOR  8'hFF
// register bus map
`define ADDR_CTRL   8'h00
`define ADDR_STATUS 8'h04
`define CTRL_RUN    0
`define CTRL_RESET  1'b1
`define ST_PC       7:0
`define ST_ZERO     8
`define ST_CARRY    9
`define ST_IE       10
`define ST_SP       14:11
`endif

// file: rtl/flow_pkg.sv
// Purpose: shared types of the program-flow core
// Assumes: nothing
// Notes:   apb request fields keep their published names
package flow_pkg;
  typedef enum logic {PH_FETCH, PH_EXEC} phase_t;
  typedef enum logic [2:0] {WB_NONE, WB_LOAD, WB_ADD, WB_SUB,
                            WB_IN, WB_OUT} wb_op_t;
  typedef struct packed {
    wb_op_t     op;
    logic       use_reg;
    logic [3:0] dest;
    logic [7:0] imm;
  } wb_t;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;
endpackage : flow_pkg

// file: rtl/small_mem.sv
// Purpose: small synchronous memory, one write and one read port
// Assumes: one clock, clock enable freezes everything
// Notes:   no reset on purpose, contents survive a core reset
`timescale 1ns/1ps
module small_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic             clk,
  input  wire logic             ce,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata_q
);
  logic [WIDTH-1:0] mem [DEPTH];
  wire              bypass = we && (waddr == raddr);

  // write-first read so a same-edge write is never seen stale
  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      if (we)
        mem[waddr] <= wdata;
      rdata_q <= bypass ? wdata : mem[raddr];
    end
  end
endmodule : small_mem

// file: rtl/return_stack.sv
// Purpose: cyclic return stack with registered top entry
// Assumes: push and pop never in the same cycle
// Notes:   full stack overwrites oldest entry, pointer only resets
`timescale 1ns/1ps
module return_stack #(
  parameter int DEPTH = 15
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       push,
  input  wire logic       pop,
  input  wire logic [7:0] push_data,
  output logic      [7:0] top_q,
  output logic      [3:0] ptr_q
);
  localparam logic [3:0] LAST = 4'(DEPTH - 1);
  localparam logic [3:0] ONE  = 4'h1;
  wire [3:0] ptr_up   = (ptr_q == LAST) ? 4'h0 : ptr_q + ONE;
  wire [3:0] ptr_down = (ptr_q == 4'h0) ? LAST : ptr_q - ONE;

  // pointer wraps both ways; no instruction can set it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ptr_q <= 4'h0;
    else if (ce && push)
      ptr_q <= ptr_up;
    else if (ce && pop)
      ptr_q <= ptr_down;
  end

  // top is read from the old pointer, settles one edge after a change
  small_mem #(.WIDTH(8), .DEPTH(DEPTH), .AW(4)) store (
    .clk     (clk),
    .ce      (ce),
    .we      (push),
    .waddr   (ptr_q),
    .wdata   (push_data),
    .raddr   (ptr_down),
    .rdata_q (top_q)
  );
endmodule : return_stack

// file: rtl/tiny_mcu_program_flow.sv
// Purpose: program-flow and port core of a tiny 8-bit controller
// Assumes: synchronous program store, user port logic on ref_clk
// Notes:   data ops finish in the fetch half of the next instruction, IN writes its register one cycle later
`timescale 1ns/1ps
`include "flow_regs.svh"
module tiny_mcu_program_flow
  import flow_pkg::*;
#(
  parameter int STACK_DEPTH = 15,
  parameter int REG_COUNT   = 16
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  output logic      [7:0]  program_location,
  input  wire logic [15:0] instruction,
  output logic      [7:0]  port_select_bus,
  output logic      [7:0]  out_data,
  input  wire logic [7:0]  in_data,
  output logic             write_pulse,
  output logic             read_pulse,
  input  wire logic        irq,
  input  wire apb_req_t    apb_req,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);
  phase_t      ph_q;
  logic [7:0]  pc_q;
  logic        zero_q, carry_q, ie_q, saved_zero_q, saved_carry_q;
  logic        irq_meta_q, irq_sync_q;
  wb_t         wb_q, wb_d;
  logic        in_pend_q;
  logic [3:0]  in_dest_q;
  logic [7:0]  port_sel_q, out_q;
  logic        wr_stb_q, rd_stb_q;
  logic        run_q;
  logic [31:0] prdata_q;
  logic        pready_q, pslverr_q;
  logic [7:0]  rx_data, ry_data, top;
  logic [3:0]  sp;

  // instruction fields, meaningful in the execute half only
  wire        exec    = (ph_q == PH_EXEC);
  wire [3:0]  op      = instruction[`FLD_OP];
  wire [2:0]  cond    = instruction[`FLD_COND];
  wire [7:0]  target  = instruction[`FLD_K];
  wire        en_bit  = instruction[`FLD_EN];
  wire        flag    = cond[`COND_CARRY] ? carry_q : zero_q;
  wire        cond_ok = !cond[`COND_TEST] ||
                        (flag ^ cond[`COND_INV]);

  // decoded control transfers; an interrupt replaces the instruction
  wire irq_take  = exec && ie_q && irq_sync_q;
  wire normal    = exec && !irq_take;
  wire jump_take = normal && (op == `OP_JUMP) && cond_ok;
  wire call_take = normal && (op == `OP_CALL) && cond_ok;
  wire ret_take  = normal && (op == `OP_RETURN) && cond_ok;
  wire reti      = normal && (op == `OP_RETI);
  wire intctl    = normal && (op == `OP_INTCTL);
  wire push      = call_take || irq_take;
  wire pop       = ret_take || reti;

  // next location: vector, target, popped entry (plus one on return), or plain increment
  wire [7:0] pc_d = irq_take                ? `IRQ_VECTOR :
                    (jump_take || call_take) ? target :
                    ret_take                 ? top + `PC_STEP :
                    reti                     ? top :
                                               pc_q + `PC_STEP;

  // write-back stage works on the instruction latched last execute
  wire [7:0] opb     = wb_q.use_reg ? ry_data : wb_q.imm;
  wire [8:0] sum     = {1'b0, rx_data} + {1'b0, opb};
  wire [8:0] diff    = {1'b0, rx_data} - {1'b0, opb};
  wire       wb_act  = (ph_q == PH_FETCH);
  wire       is_add  = wb_act && (wb_q.op == WB_ADD);
  wire       is_sub  = wb_act && (wb_q.op == WB_SUB);
  wire       alu_we  = wb_act && (wb_q.op == WB_LOAD || is_add ||
                                  is_sub);
  wire [7:0] alu_res = is_add ? sum[7:0] : is_sub ? diff[7:0] : opb;
  wire       rf_we   = alu_we || in_pend_q;
  wire [3:0] rf_wa   = in_pend_q ? in_dest_q : wb_q.dest;
  wire [7:0] rf_wd   = in_pend_q ? in_data : alu_res;

  // data-op decode for the write-back stage
  always_comb
  begin
    wb_d         = '0;
    wb_d.op      = WB_NONE;
    wb_d.use_reg = op[0];
    wb_d.dest    = instruction[`FLD_RX];
    wb_d.imm     = instruction[`FLD_K];
    if (normal)
    begin
      case (op)
        `OP_LOAD_K, `OP_LOAD_R: wb_d.op = WB_LOAD;
        `OP_ADD_K, `OP_ADD_R:   wb_d.op = WB_ADD;
        `OP_SUB_K, `OP_SUB_R:   wb_d.op = WB_SUB;
        `OP_IN_K, `OP_IN_R:     wb_d.op = WB_IN;
        `OP_OUT_K, `OP_OUT_R:   wb_d.op = WB_OUT;
        default:                wb_d.op = WB_NONE;
      endcase
    end
  end

  // register bus decode
  wire apb_go   = apb_req.psel && apb_req.penable && !pready_q;
  wire hit_ctrl = (apb_req.paddr == `ADDR_CTRL);
  wire hit_stat = (apb_req.paddr == `ADDR_STATUS);
  logic [31:0] status;
  always_comb
  begin
    status              = '0;
    status[`ST_PC]      = pc_q;
    status[`ST_ZERO]    = zero_q;
    status[`ST_CARRY]   = carry_q;
    status[`ST_IE]      = ie_q;
    status[`ST_SP]      = sp;
  end
  wire [31:0] rd_word = hit_ctrl ? {31'h0, run_q} :
                        hit_stat ? status : 32'h0;

  // two operand reads keyed by the fetched word, both read ports alike
  small_mem #(.WIDTH(8), .DEPTH(REG_COUNT), .AW(4)) bank_x (
    .clk     (ref_clk),
    .ce      (ce),
    .we      (rf_we),
    .waddr   (rf_wa),
    .wdata   (rf_wd),
    .raddr   (instruction[`FLD_RX]),
    .rdata_q (rx_data)
  );
  small_mem #(.WIDTH(8), .DEPTH(REG_COUNT), .AW(4)) bank_y (
    .clk     (ref_clk),
    .ce      (ce),
    .we      (rf_we),
    .waddr   (rf_wa),
    .wdata   (rf_wd),
    .raddr   (instruction[`FLD_RY]),
    .rdata_q (ry_data)
  );

  // cyclic stack, fifteen entries
  return_stack #(.DEPTH(STACK_DEPTH)) stack (
    .clk       (ref_clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .push      (push),
    .pop       (pop),
    .push_data (pc_q),
    .top_q     (top),
    .ptr_q     (sp)
  );

  // irq is foreign to this clock, so it passes two flops first
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_meta_q <= 1'b0;
      irq_sync_q <= 1'b0;
    end
    else if (ce)
    begin
      irq_meta_q <= irq;
      irq_sync_q <= irq_meta_q;
    end
  end

  // phase and counter: fetch waits here while software halts the core
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ph_q <= PH_FETCH;
      pc_q <= `PC_RESET;
    end
    else if (ce)
    begin
      case (ph_q)
        PH_FETCH: if (run_q) ph_q <= PH_EXEC;
        PH_EXEC:
        begin
          ph_q <= PH_FETCH;
          pc_q <= pc_d;
        end
        default: ph_q <= PH_FETCH;
      endcase
    end
  end

  // flags: only data ops, irq entry, irq exit and the intctl op touch them
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      zero_q        <= 1'b0;
      carry_q       <= 1'b0;
      saved_zero_q  <= 1'b0;
      saved_carry_q <= 1'b0;
      ie_q          <= 1'b0;
    end
    else if (ce)
    begin
      if (is_add || is_sub)
      begin
        zero_q  <= (alu_res == 8'h00);
        carry_q <= is_add ? sum[8] : diff[8];
      end
      if (irq_take)
      begin
        saved_zero_q  <= zero_q;
        saved_carry_q <= carry_q;
        ie_q          <= 1'b0;
      end
      else if (reti)
      begin
        zero_q  <= saved_zero_q;
        carry_q <= saved_carry_q;
        ie_q    <= en_bit;
      end
      else if (intctl)
        ie_q <= en_bit;
    end
  end

  // write-back slot is consumed once, so a halt cannot repeat it
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wb_q      <= '0;
      in_pend_q <= 1'b0;
      in_dest_q <= 4'h0;
    end
    else if (ce)
    begin
      wb_q      <= exec ? wb_d : '0;
      in_pend_q <= wb_act && (wb_q.op == WB_IN);
      in_dest_q <= wb_q.dest;
    end
  end

  // port side: select and data settle with the strobe, one-cycle pulses
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port_sel_q <= 8'h00;
      out_q      <= 8'h00;
      wr_stb_q   <= 1'b0;
      rd_stb_q   <= 1'b0;
    end
    else if (ce)
    begin
      wr_stb_q <= wb_act && (wb_q.op == WB_OUT);
      rd_stb_q <= wb_act && (wb_q.op == WB_IN);
      if (wb_act && (wb_q.op == WB_OUT || wb_q.op == WB_IN))
        port_sel_q <= opb;
      if (wb_act && (wb_q.op == WB_OUT))
        out_q <= rx_data;
    end
  end

  // apb slave, one wait state; unmapped offsets answer with pslverr
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_q     <= `CTRL_RESET;
      prdata_q  <= 32'h0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else if (ce)
    begin
      pready_q  <= apb_go;
      pslverr_q <= apb_go && !hit_ctrl && !hit_stat;
      if (apb_go && !apb_req.pwrite)
        prdata_q <= rd_word;
      if (apb_go && apb_req.pwrite && hit_ctrl)
        run_q <= apb_req.pwdata[`CTRL_RUN];
    end
  end

  assign program_location = pc_q;
  assign port_select_bus  = port_sel_q;
  assign out_data         = out_q;
  assign write_pulse      = wr_stb_q;
  assign read_pulse       = rd_stb_q;
  assign prdata           = prdata_q;
  assign pready           = pready_q;
  assign pslverr          = pslverr_q;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_irq_entry;
    irq_take && ce;
  endsequence
  sequence s_vector_held;
    (pc_q == `IRQ_VECTOR) && !ie_q;
  endsequence

  chk_exec_half: assert property (
    (exec && ce) |=> (ph_q == PH_FETCH))
    else $error("execute half not followed by fetch half");
  chk_pc_step: assert property (
    (normal && ce && !jump_take && !call_take && !ret_take && !reti)
    |=> (pc_q == $past(pc_q) + `PC_STEP))
    else $error("counter did not step by one");
  chk_pc_wrap: assert property (
    (normal && ce && (op == `OP_OUT_K) && (pc_q == `IRQ_VECTOR))
    |=> (pc_q == `PC_RESET))
    else $error("counter did not wrap to zero");
  chk_jump_load: assert property (
    (jump_take && ce) |=> (pc_q == $past(target)) && $stable(zero_q))
    else $error("jump target or flags wrong");
  chk_jump_flags: assert property (
    (normal && ce && (op == `OP_JUMP))
    |=> $stable(zero_q) && $stable(carry_q))
    else $error("jump changed a flag");
  chk_call_push: assert property (
    (call_take && ce && (sp == 4'h0)) |=> (sp == 4'h1)
    ##2 (top == $past(pc_q, 3)))
    else $error("call did not push its location");
  chk_ret_plus: assert property (
    (ret_take && ce) |=> (pc_q == $past(top) + `PC_STEP))
    else $error("return did not load entry plus one");
  chk_reti_exact: assert property (
    (reti && ce) |=> (pc_q == $past(top)) && (ie_q == $past(en_bit))
    && (zero_q == $past(saved_zero_q)))
    else $error("interrupt exit wrong");
  chk_irq_entry: assert property (
    s_irq_entry |=> s_vector_held ##0 (saved_carry_q == $past(carry_q)))
    else $error("interrupt entry wrong");
  chk_out_pulse: assert property (
    (wb_act && ce && (wb_q.op == WB_OUT))
    |=> write_pulse ##1 (!write_pulse || $past(wb_q.op) == WB_OUT))
    else $error("output strobe not a single pulse");
endmodule : tiny_mcu_program_flow

// file: test/flow_partner.sv
// Purpose: program store and user port logic facing the flow core
// Assumes: one clock shared with the core; bench fills mem while reset is held
// Notes:   logs every port write with a cycle stamp for spacing checks
`timescale 1ns/1ps
module flow_partner (
  input  wire logic        clk,
  input  wire logic [7:0]  program_location,
  output logic      [15:0] instruction,
  input  wire logic [7:0]  port_select_bus,
  input  wire logic [7:0]  out_data,
  input  wire logic        write_pulse,
  input  wire logic        read_pulse,
  output logic      [7:0]  in_data
);
  logic [15:0] mem [256];
  logic [47:0] wlog [$];
  int unsigned cyc = 0;

  // one-edge registered read, as a single-port block memory does
  always_ff @(posedge clk)
  begin
    instruction <= mem[program_location];
  end

  // write strobe used as write enable; stamp lets the bench time it
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (write_pulse === 1'b1)
    begin
      wlog.push_back({cyc, port_select_bus, out_data});
    end
  end

  // data only meaningful under the read strobe, else changes each cycle
  assign in_data = (read_pulse === 1'b1) ? (port_select_bus ^ 8'hA5)
                                         : ~cyc[7:0];
endmodule : flow_partner

// file: test/tiny_mcu_program_flow_tb.sv
// Purpose: self-checking bench for the program-flow core
// Assumes: apb master tasks, partner model supplies program and ports
// Notes:   two programs; the second runs after a mid-run reset
`timescale 1ns/1ps
`include "flow_regs.svh"
module tiny_mcu_program_flow_tb
  import flow_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        rst_n;
  logic        ce;
  logic        irq;
  apb_req_t    req;
  logic [7:0]  program_location;
  logic [15:0] instruction;
  logic [7:0]  port_select_bus;
  logic [7:0]  out_data;
  logic [7:0]  in_data;
  logic        write_pulse;
  logic        read_pulse;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  int          n_fail = 0;
  int          n_tests = 0;
  int          n;
  logic [31:0] last_cyc;
  // entries are {location, instruction word}
  logic [23:0] prog1 [] = '{24'h000000, 24'h014001, 24'h02A710,
    24'h03A410, 24'h04A606, 24'h0580EE, 24'h06B520, 24'h078001,
    24'h0801F0, 24'h099010, 24'h0A7210, 24'h0B8202, 24'h0C0F7E,
    24'h0D8FFF, 24'h0E040F, 24'h0FB040, 24'h108405, 24'h11E001,
    24'h12A012, 24'h20C700, 24'h21C600, 24'h404401, 24'h41B540,
    24'h42C000, 24'hFFA030, 24'h300E05, 24'h312E01, 24'h328E04,
    24'h33D001};
  logic [23:0] prog2 [] = '{24'h008E06, 24'h010410, 24'h024E06,
    24'h03A4FF, 24'h04B040, 24'h058407, 24'hFF8008};

  tiny_mcu_program_flow dut (
    .ref_clk          (ref_clk),
    .rst_n            (rst_n),
    .ce               (ce),
    .program_location (program_location),
    .instruction      (instruction),
    .port_select_bus  (port_select_bus),
    .out_data         (out_data),
    .in_data          (in_data),
    .write_pulse      (write_pulse),
    .read_pulse       (read_pulse),
    .irq              (irq),
    .apb_req          (req),
    .prdata           (prdata),
    .pready           (pready),
    .pslverr          (pslverr)
  );

  flow_partner rom (
    .clk              (ref_clk),
    .program_location (program_location),
    .instruction      (instruction),
    .port_select_bus  (port_select_bus),
    .out_data         (out_data),
    .write_pulse      (write_pulse),
    .read_pulse       (read_pulse),
    .in_data          (in_data)
  );

  // 100 MHz
  always #5 ref_clk = ~ref_clk;

  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_v

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge ref_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    // no cycle count assumed; only the watchdog ends a hung wait
    do
    begin
      @(posedge ref_clk);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    req <= '0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [31:0] msk, input logic experr);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h00000000, r, e);
    chk_v(r & msk, exp, "read data");
    chk_v({31'h0, e}, {31'h0, experr}, "slave error");
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic experr);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk_v({31'h0, e}, {31'h0, experr}, "slave error");
  endtask : wr

  // next logged port write; dt < 0 skips the spacing check
  task automatic chk_w(input logic [7:0] p, input logic [7:0] d,
                       input int dt);
    logic [47:0] w;
    int          k;
    k = 0;
    while (rom.wlog.size() == 0 && k < 2000)
    begin
      @(posedge ref_clk);
      k++;
    end
    w = (rom.wlog.size() == 0) ? 48'hX : rom.wlog.pop_front();
    chk_v({16'h0, w[15:0]}, {16'h0, p, d}, "port write");
    if (dt >= 0)
    begin
      chk_v(w[47:16] - last_cyc, 32'(dt), "write spacing");
    end
    last_cyc = w[47:16];
  endtask : chk_w

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
    begin
      $display("SIMULATION PASSED");
    end
    else
    begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  // whole run needs well under 3000 cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    test_done;
  end

  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    irq = 1'b0;
    req = '0;
    for (int i = 0; i < 256; i++) rom.mem[i] = 16'hF000;
    foreach (prog1[i]) rom.mem[prog1[i][23:16]] = prog1[i][15:0];
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk_w(8'h01, 8'hFF, -1);
    chk_w(8'hF0, 8'hFF, 4);
    chk_w(8'h02, 8'h55, 4);
    chk_w(8'hFF, 8'h7E, 4);
    chk_w(8'h05, 8'h00, -1);
    $display("test branch_call_port done");
    repeat (10) @(posedge ref_clk);
    rd(`ADDR_STATUS, 32'h00000512, 32'hFFFFFFFF, 1'b0);
    rd(`ADDR_CTRL, 32'h00000001, 32'hFFFFFFFF, 1'b0);
    rd(8'h08, 32'h00000000, 32'hFFFFFFFF, 1'b1);
    wr(8'h08, 32'h00000001, 1'b1);
    wr(`ADDR_STATUS, 32'hFFFFFFFF, 1'b0);
    rd(`ADDR_STATUS, 32'h00000512, 32'hFFFFFFFF, 1'b0);
    wr(`ADDR_CTRL, 32'h00000000, 1'b0);
    rd(`ADDR_CTRL, 32'h00000000, 32'hFFFFFFFF, 1'b0);
    wr(`ADDR_CTRL, 32'h00000001, 1'b0);
    $display("test registers done");
    // level request; dropped once the vector is fetched
    irq <= 1'b1;
    n = 0;
    while (program_location !== 8'hFF && n < 100)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk_v({24'h0, program_location}, 32'h000000FF, "vector");
    irq <= 1'b0;
    chk_w(8'h04, 8'h06, -1);
    repeat (20) @(posedge ref_clk);
    rd(`ADDR_STATUS, 32'h00000512, 32'hFFFFFFFF, 1'b0);
    $display("test interrupt done");
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    foreach (prog2[i]) rom.mem[prog2[i][23:16]] = prog2[i][15:0];
    rst_n <= 1'b1;
    rd(`ADDR_STATUS, 32'h00000000, 32'h00007F00, 1'b0);
    chk_w(8'h06, 8'h06, -1);
    // ce low for four edges must stretch the next spacing by four
    ce <= 1'b0;
    repeat (4) @(posedge ref_clk);
    ce <= 1'b1;
    chk_w(8'h08, 8'hFF, 12);
    chk_w(8'h06, 8'h00, 2);
    repeat (300) @(posedge ref_clk);
    rd(`ADDR_STATUS, 32'h00000142, 32'h000007FF, 1'b0);
    chk_v(rom.wlog.size(), 32'h0, "extra port write");
    $display("test reset_wrap_overflow done");
    test_done;
  end
endmodule : tiny_mcu_program_flow_tb
